// ---- design/frt_pkg.sv ----
/*
  Package for the free-running tick timer: widths, bit positions,
  reset values and the tick divider figures.
  Assumes a 25 MHz system clock; all users qualify names with frt_pkg::.
*/
package frt_pkg;
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned LO_W         = 8;
  localparam int unsigned HI_W         = CNT_W - LO_W;
  localparam int unsigned SRC_FAST_BIT = 6;
  localparam int unsigned SRC_SLOW_BIT = 9;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TICK_HZ      = 1_000_000;
  localparam int unsigned TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int unsigned DIV_W        = $clog2(TICK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [CNT_W-1:0] CNT_RST  = 12'h000;
  localparam logic [HI_W-1:0]  HOLD_RST = 4'h0;

  typedef struct packed {
    logic [LO_W-1:0] lo_data;
    logic [HI_W-1:0] hi_data;
  } frt_rd_t;

  typedef struct packed {
    logic fast_irq;
    logic slow_irq;
  } frt_irq_t;
endpackage

// ---- design/frt_rise_det.sv ----
/*
  Rising-edge detector: one-cycle pulse when an enabled source bit goes 0 to 1.
  Assumes the source is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module frt_rise_det (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic src,
  input  wire logic enable,
  output logic      pulse
);
  logic src_d_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src;
    end
  end

  // Falling edges are ignored by design
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= enable & src & ~src_d_r;
    end
  end

  a_rise_only_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pulse |-> $past(enable) && $past(src) && !$past(src_d_r)) else $error("pulse without rise");
endmodule

// ---- design/frt_timer.sv ----
/*
  Free-running 12-bit tick timer with split low/high read and two edge interrupts.
  Assumes firmware reads are one-cycle strobes synchronous to clk_sys.
*/
// Overview of operation
// - 12-bit counter advances every microsecond
// - Low-byte read latches upper four bits
// - High read returns latched nibble only
// - Interrupt sources from counter bits 6, 9
// - Enabled sources fire on rising edge only
`timescale 1ns/1ps
module frt_timer (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            rd_lo,
  input  wire logic            rd_hi,
  input  wire logic            fast_en,
  input  wire logic            slow_en,
  output frt_pkg::frt_rd_t     rd_data,
  output frt_pkg::frt_irq_t    irq,
  output logic                 tick_us
);
  logic [frt_pkg::DIV_W-1:0] div_r;
  logic [frt_pkg::CNT_W-1:0] cnt_r;
  logic [frt_pkg::HI_W-1:0]  hold_r;
  logic                      fast_p;
  logic                      slow_p;

  // Divider gives the 1 MHz enable; one clock, no derived clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= '0;
      tick_us <= 1'b0;
    end else begin
      tick_us <= (div_r == frt_pkg::DIV_LAST);
      if (div_r == frt_pkg::DIV_LAST) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // Natural overflow wraps all-ones to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= frt_pkg::CNT_RST;
    end else if (tick_us) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Holder catches the nibble seen by the same low read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= frt_pkg::HOLD_RST;
    end else if (rd_lo) begin
      hold_r <= cnt_r[frt_pkg::CNT_W-1:frt_pkg::LO_W];
    end
  end

  // Read data registered; high half never shows the live count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      if (rd_lo) begin
        rd_data.lo_data <= cnt_r[frt_pkg::LO_W-1:0];
      end
      if (rd_hi) begin
        rd_data.hi_data <= hold_r;
      end
    end
  end

  frt_rise_det u_fast (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .src     (cnt_r[frt_pkg::SRC_FAST_BIT]),
    .enable  (fast_en),
    .pulse   (fast_p)
  );

  frt_rise_det u_slow (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .src     (cnt_r[frt_pkg::SRC_SLOW_BIT]),
    .enable  (slow_en),
    .pulse   (slow_p)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= '0;
    end else begin
      irq.fast_irq <= fast_p;
      irq.slow_irq <= slow_p;
    end
  end

  // Shared steps; irq lags a bit rise by two registers
  sequence s_tick_then_step;
    tick_us ##1 (cnt_r == $past(cnt_r) + 12'h001);
  endsequence

  sequence s_fast_rise;
    $rose(cnt_r[frt_pkg::SRC_FAST_BIT]) && fast_en;
  endsequence

  sequence s_slow_rise;
    $rose(cnt_r[frt_pkg::SRC_SLOW_BIT]) && slow_en;
  endsequence

  sequence s_tick_gap;
    !tick_us [*8] ##1 !tick_us [*8] ##1 !tick_us [*8];
  endsequence

  a_count_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_us
    |-> s_tick_then_step)
    else $error("count did not step");

  a_count_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tick_us
    |=> $stable(cnt_r))
    else $error("count moved without tick");

  a_tick_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_us
    |=> s_tick_gap ##1 tick_us)
    else $error("tick period not 25 cycles");

  a_tick_at_last: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (div_r == frt_pkg::DIV_LAST)
    |=> tick_us)
    else $error("tick missing after last divider step");

  a_div_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1
    |-> (div_r <= frt_pkg::DIV_LAST))
    else $error("divider out of range");

  a_hold_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_lo
    |=> hold_r == $past(cnt_r[frt_pkg::CNT_W-1:frt_pkg::LO_W]))
    else $error("nibble not latched");

  a_hold_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_lo
    |=> $stable(hold_r))
    else $error("holder changed without low read");

  a_lo_data_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_lo
    |=> rd_data.lo_data == $past(cnt_r[frt_pkg::LO_W-1:0]))
    else $error("low read not from count");

  a_lo_data_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_lo
    |=> $stable(rd_data.lo_data))
    else $error("low half moved without read");

  a_hi_from_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_hi
    |=> rd_data.hi_data == $past(hold_r))
    else $error("high read not from holder");

  a_hi_data_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_hi
    |=> $stable(rd_data.hi_data))
    else $error("high half moved without read");

  a_fast_irq_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_fast_rise
    |-> ##2 irq.fast_irq)
    else $error("fast source rise lost");

  a_slow_irq_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_slow_rise
    |-> ##2 irq.slow_irq)
    else $error("slow source rise lost");

  a_no_irq_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(cnt_r[frt_pkg::SRC_SLOW_BIT])
    |-> ##2 !irq.slow_irq)
    else $error("slow irq on falling edge");

  a_no_fast_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(cnt_r[frt_pkg::SRC_FAST_BIT])
    |-> ##2 !irq.fast_irq)
    else $error("fast irq on falling edge");

  a_fast_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.fast_irq
    |-> $past(fast_en, 2))
    else $error("fast irq while disabled");

  a_slow_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.slow_irq
    |-> $past(slow_en, 2))
    else $error("slow irq while disabled");

  a_fast_needs_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.fast_irq
    |-> $past(cnt_r[frt_pkg::SRC_FAST_BIT], 2) && !$past(cnt_r[frt_pkg::SRC_FAST_BIT], 3))
    else $error("fast irq without rise");

  a_slow_needs_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.slow_irq
    |-> $past(cnt_r[frt_pkg::SRC_SLOW_BIT], 2) && !$past(cnt_r[frt_pkg::SRC_SLOW_BIT], 3))
    else $error("slow irq without rise");

  a_fast_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.fast_irq
    |=> !irq.fast_irq)
    else $error("fast irq longer than one cycle");

  a_slow_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq.slow_irq
    |=> !irq.slow_irq)
    else $error("slow irq longer than one cycle");

  a_wrap_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cnt_r == 12'hfff) && tick_us
    |=> cnt_r == frt_pkg::CNT_RST)
    else $error("no wrap");

  a_tick_seq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_tick_then_step
    |=> !tick_us)
    else $error("tick stuck");
endmodule

// ---- dv/tb_free_running_tick_timer.sv ----
/*
  Self-checking bench for the free-running tick timer.
  Assumes frt_pkg and frt_timer are compiled first.
*/
`timescale 1ns/1ps
module tb_free_running_tick_timer;
  logic              clk_sys;
  logic              rst_n;
  logic              rd_lo;
  logic              rd_hi;
  logic              fast_en;
  logic              slow_en;
  logic              tick_us;
  frt_pkg::frt_rd_t  rd_data;
  frt_pkg::frt_irq_t irq;
  int                n_errors;
  int                n_compared;
  int                n_ticks;
  int                n_fast;
  int                n_slow;
  int                a;
  int                b;
  logic [11:0]       e;

  frt_timer dut (.clk_sys(clk_sys), .rst_n(rst_n), .rd_lo(rd_lo), .rd_hi(rd_hi), .fast_en(fast_en),
    .slow_en(slow_en), .rd_data(rd_data), .irq(irq), .tick_us(tick_us));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Event counts cleared with the design so expectations restart too
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_ticks <= 0;
      n_fast  <= 0;
      n_slow  <= 0;
    end else begin
      if (tick_us === 1'b1) n_ticks <= n_ticks + 1;
      if (irq.fast_irq === 1'b1) n_fast <= n_fast + 1;
      if (irq.slow_irq === 1'b1) n_slow <= n_slow + 1;
    end
  end

  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task clk1(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Mid-interval sampling keeps reads clear of the increment edge
  task to_mid;
    for (int i = 0; i < 30 && tick_us !== 1'b1; i++) clk1(1);
    clk1(12);
  endtask

  task rd(input logic hi);
    if (hi) rd_hi = 1'b1;
    else rd_lo = 1'b1;
    clk1(1);
    rd_hi = 1'b0;
    rd_lo = 1'b0;
    clk1(1);
  endtask

  task t_tick;
    to_mid();
    a = n_ticks;
    clk1(250);
    chk(12'(n_ticks - a), 12'h00a);
  endtask

  task t_read;
    to_mid();
    e = 12'(n_ticks);
    rd(1'b0);
    chk({4'h0, rd_data.lo_data}, {4'h0, e[7:0]});
    clk1(6400);
    rd(1'b1);
    chk({8'h00, rd_data.hi_data}, {8'h00, e[11:8]});
    to_mid();
    e = 12'(n_ticks);
    rd(1'b0);
    rd(1'b1);
    chk({rd_data.lo_data, rd_data.hi_data}, {e[7:0], e[11:8]});
  endtask

  task t_irq(input logic en, input logic [11:0] nf, input logic [11:0] ns);
    fast_en = en;
    slow_en = en;
    clk1(10);
    a = n_fast;
    b = n_slow;
    clk1(25600);
    chk(12'(n_fast - a), nf);
    chk(12'(n_slow - b), ns);
  endtask

  initial begin
    {rst_n, rd_lo, rd_hi, fast_en, slow_en} = 5'h00;
    n_errors = 0;
    n_compared = 0;
    clk1(4);
    chk(rd_data, 12'h000);
    rst_n = 1'b1;
    t_tick();
    t_read();
    t_irq(1'b1, 12'h008, 12'h001);
    t_irq(1'b0, 12'h000, 12'h000);
    rst_n = 1'b0;
    clk1(1);
    chk(rd_data, 12'h000);
    chk({9'h000, irq, tick_us}, 12'h000);
    results();
  end

  // Tests need about 58000 cycles
  initial begin
    #(70000 * 40);
    n_errors++;
    results();
  end
endmodule
